// >>> result_transfer_pkg.sv
// constants shared by the result transfer unit
//
// Contract
// R1 - unit active while transfer count is nonzero; each result load starts one transfer
// R2 - one bus cycle per transfer; running CPU stalled for exactly that cycle
// R3 - software configures the unit only while no conversion is in progress
// R4 - one-block mode: n words from start address up to start plus 2n-2
// R5 - hidden pointer starts at start, counter at n; step +2 and -1
// R6 - one-block: after counter hits zero, idle until start address is written; a count write also rearms the walk here
// R7 - one-block mode sets interrupt flag only after the whole block
// R8 - two-block mode: second block spans start plus 2n to start plus 4n-2
// R9 - two-block: end of block one sets flag and block-one-full
// R10 - after block one, counter reloads to n and next results go to block two
// R11 - after n transfers into block two, set flag and clear block-one-full
// R12 - continuous: reload pointer and counter after final block, resume block one
// R13 - continuous cleared: stop once the current final block completes
// R14 - each transfer: one or two sync cycles, one stalled transfer, one wait
// R15 - clock running with CPU off: transfer without waking the CPU
// R16 - clock off: restart it from internal oscillator only during the transfer
// R17 - at most 3 cycles active, 4 low power, plus 6 us deep oscillator start
// R18 - channel code 1010 selects temperature sensor, otherwise like external channel
// R19 - temperature channel turns on reference generator, nothing else
// R20 - software programs sample period above 30 us for temperature channel
// R21 - count zero: flag set on every result load
// R22 - interrupt request when flag, its enable and global enable are set
// R23 - flag clears when serviced or by software write
// R24 - each transfer is one aligned 16-bit word write at the pointer
package result_transfer_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] ctrl_offset   = 8'h00;
    localparam logic [7:0] count_offset  = 8'h04;
    localparam logic [7:0] start_offset  = 8'h08;
    localparam logic [7:0] status_offset = 8'h0c;
    localparam logic [7:0] result_offset = 8'h10;
    // control register fields
    localparam int two_block_bit   = 0;
    localparam int continuous_bit  = 1;
    localparam int irq_enable_bit  = 2;
    localparam int channel_lsb     = 4;
    localparam int channel_msb     = 7;
    // status register fields
    localparam int flag_bit        = 0;
    localparam int block_one_bit   = 1;
    localparam int active_bit      = 2;
    // reset values
    localparam logic [15:0] start_reset = 16'h0200;
    localparam logic [7:0]  ctrl_reset  = 8'h00;
    localparam logic [7:0]  count_reset = 8'h00;
    // channel code of the temperature sensor
    localparam logic [3:0] temp_channel = 4'ha;
    // pointer step of one word
    localparam logic [15:0] word_step = 16'h0002;
    // oscillator start time and clock
    localparam int osc_start_ns   = 6000;
    localparam int clk_period_ns  = 10;
    localparam int osc_start_cycles = (osc_start_ns + clk_period_ns - 1) / clk_period_ns;
    localparam logic [9:0] osc_count_load = 10'(osc_start_cycles - 1);
endpackage

// >>> xfer_if.sv
// handshake between transfer controller and transfer cycle sequencer
`timescale 1ns/1ps
interface xfer_if;
    logic start;
    logic cpu_off;
    logic clock_off;
    logic deep;
    logic busy;
    logic xfer;
    logic done;
    logic stall;
    logic clk_req;
    logic osc_sel;
    modport seq (input start, input cpu_off, input clock_off, input deep,
                 output busy, output xfer, output done, output stall, output clk_req, output osc_sel);
    modport ctl (output start, output cpu_off, output clock_off, output deep,
                 input busy, input xfer, input done, input stall, input clk_req, input osc_sel);
endinterface

// >>> xfer_sequencer.sv
// cycle sequencer for one result transfer
`timescale 1ns/1ps
module xfer_sequencer (
    input wire logic mclk,
    input wire logic rst,
    xfer_if.seq      sq
);
    typedef enum logic [2:0] {
        st_idle  = 3'b000,
        st_osc   = 3'b001,
        st_sync1 = 3'b010,
        st_sync2 = 3'b011,
        st_xfer  = 3'b100,
        st_wait  = 3'b101
    } seq_state_t;

    seq_state_t state;
    logic       low_power;
    logic       cpu_off_q;
    logic [9:0] osc_cnt;

    // phase walk; every strobe is a flop so the top sees registered outputs
    always_ff @(posedge mclk) begin
        if (rst) begin
            state     <= st_idle;
            low_power <= 1'b0;
            cpu_off_q <= 1'b0;
            osc_cnt   <= 10'h000;
            sq.busy   <= 1'b0;
            sq.xfer   <= 1'b0;
            sq.done   <= 1'b0;
            sq.stall  <= 1'b0;
            sq.clk_req <= 1'b0;
            sq.osc_sel <= 1'b0;
        end else begin
            sq.xfer  <= 1'b0;
            sq.done  <= 1'b0;
            sq.stall <= 1'b0;
            case (state)
                st_idle: begin
                    if (sq.start) begin
                        sq.busy   <= 1'b1;
                        low_power <= sq.cpu_off | sq.clock_off; // see R17
                        cpu_off_q <= sq.cpu_off | sq.clock_off;
                        if (sq.clock_off) begin
                            sq.clk_req <= 1'b1; // see R16
                            sq.osc_sel <= 1'b1;
                        end
                        if (sq.clock_off && sq.deep) begin
                            osc_cnt <= result_transfer_pkg::osc_count_load; // see R17
                            state   <= st_osc;
                        end else begin
                            state <= st_sync1;
                        end
                    end
                end
                st_osc: begin
                    if (osc_cnt == 10'h000) begin
                        state <= st_sync1;
                    end else begin
                        osc_cnt <= osc_cnt - 10'h001;
                    end
                end
                st_sync1: begin
                    // low power needs the second sync cycle
                    if (low_power) begin
                        state <= st_sync2; // see R14
                    end else begin
                        state    <= st_xfer;
                        sq.xfer  <= 1'b1;
                        sq.stall <= ~cpu_off_q; // see R2
                    end
                end
                st_sync2: begin
                    state    <= st_xfer;
                    sq.xfer  <= 1'b1;
                    sq.stall <= ~cpu_off_q; // see R15
                end
                st_xfer: begin
                    state <= st_wait; // see R14
                end
                st_wait: begin
                    // clock request dropped so a stopped clock goes off again
                    sq.done    <= 1'b1;
                    sq.busy    <= 1'b0;
                    sq.clk_req <= 1'b0; // see R16
                    sq.osc_sel <= 1'b0;
                    state      <= st_idle;
                end
                default: begin
                    state <= st_idle;
                end
            endcase
        end
    end
endmodule

// >>> adc_result_transfer_ctrl.sv
// result transfer controller top: bus registers, block pointer and counter, flag
`timescale 1ns/1ps
module adc_result_transfer_ctrl (
    input  wire logic        mclk,
    input  wire logic        rst,
    // register bus
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // converter core
    input  wire logic [9:0]  conversion_result,
    input  wire logic        result_load,
    // cpu and clock system
    input  wire logic        global_irq_enable,
    input  wire logic        irq_serviced,
    input  wire logic        cpu_off,
    input  wire logic        main_clock_off,
    input  wire logic        deep_low_power_level,
    output logic             irq,
    output logic             cpu_stall,
    output logic             mclk_request,
    output logic             internal_osc_clock_sel,
    // memory bus
    output logic             mem_we,
    output logic [15:0]      mem_addr,
    output logic [15:0]      mem_wdata,
    // analog side and block status
    output logic             ref_gen_on,
    output logic             block_one_full
);
    // settings
    logic [7:0]  ctrl;
    logic [7:0]  transfer_count_reg;
    logic [15:0] block_start_addr;
    // hidden engine state
    logic [15:0] pointer;
    logic [7:0]  counter;
    logic        in_block_two;
    logic        halted;
    logic        conv_irq_flag;
    logic [15:0] result_word;
    logic        start_q;

    logic        two_block_select;
    logic        continuous_transfer;
    logic        conv_irq_enable;
    logic [3:0]  input_channel_select;
    logic        bus_write;
    logic        bus_setup;
    logic        wr_ctrl;
    logic        wr_count;
    logic        wr_start;
    logic        wr_status;
    logic        unit_active;
    logic        last_word;
    logic        block_done_set;
    logic        direct_set;
    logic        next_flag;

    xfer_if xif ();

    xfer_sequencer u_seq (
        .mclk (mclk),
        .rst  (rst),
        .sq   (xif.seq)
    );

    // true when the address names a mapped register
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == result_transfer_pkg::ctrl_offset) || (a == result_transfer_pkg::count_offset) ||
                    (a == result_transfer_pkg::start_offset) || (a == result_transfer_pkg::status_offset) ||
                    (a == result_transfer_pkg::result_offset);
    endfunction

    // temperature sensor decode
    function automatic logic is_temp_channel(input logic [3:0] ch);
        is_temp_channel = (ch == result_transfer_pkg::temp_channel); // see R18
    endfunction

    assign two_block_select     = ctrl[result_transfer_pkg::two_block_bit];
    assign continuous_transfer  = ctrl[result_transfer_pkg::continuous_bit];
    assign conv_irq_enable      = ctrl[result_transfer_pkg::irq_enable_bit];
    assign input_channel_select = ctrl[result_transfer_pkg::channel_msb:result_transfer_pkg::channel_lsb];

    // bus decode; writes land at the access edge only
    assign bus_setup = psel & ~penable;
    assign bus_write = psel & penable & pready & pwrite & ~pslverr;
    assign wr_ctrl   = bus_write & (paddr == result_transfer_pkg::ctrl_offset);
    assign wr_count  = bus_write & (paddr == result_transfer_pkg::count_offset);
    assign wr_start  = bus_write & (paddr == result_transfer_pkg::start_offset);
    assign wr_status = bus_write & (paddr == result_transfer_pkg::status_offset);

    // engine bookkeeping
    assign unit_active    = (transfer_count_reg != 8'h00) & ~halted; // see R1
    assign last_word      = (counter == 8'h01);
    assign block_done_set = xif.done & last_word; // see R7
    assign direct_set     = result_load & (transfer_count_reg == 8'h00); // see R21

    // set beats both clears so a block end is never lost
    assign next_flag = (block_done_set | direct_set) ? 1'b1 :
                       ((irq_serviced | (wr_status & pwdata[result_transfer_pkg::flag_bit])) ? 1'b0 :
                       conv_irq_flag); // see R23

    // sequencer inputs; clock state is sampled when a transfer starts
    assign xif.start     = start_q;
    assign xif.cpu_off   = cpu_off;
    assign xif.clock_off = main_clock_off;
    assign xif.deep      = deep_low_power_level;

    // memory bus and cpu strobes come from sequencer flops
    assign mem_we                 = xif.xfer; // see R24
    assign cpu_stall              = xif.stall; // see R2
    assign mclk_request           = xif.clk_req; // see R16
    assign internal_osc_clock_sel = xif.osc_sel;
    assign mem_addr               = pointer;
    assign mem_wdata              = result_word;

    // bus answer: data prepared in setup, ready for one access cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= bus_setup;
            pslverr <= bus_setup & ~is_mapped(paddr);
            if (bus_setup) begin
                case (paddr)
                    result_transfer_pkg::ctrl_offset:   prdata <= {24'h000000, ctrl};
                    result_transfer_pkg::count_offset:  prdata <= {24'h000000, transfer_count_reg};
                    result_transfer_pkg::start_offset:  prdata <= {16'h0000, block_start_addr};
                    result_transfer_pkg::status_offset: prdata <= {29'h00000000, unit_active, block_one_full,
                                                                   conv_irq_flag};
                    result_transfer_pkg::result_offset: prdata <= {22'h000000, conversion_result};
                    default:                            prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // software settings; software only rewrites them while the converter is idle
    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl               <= result_transfer_pkg::ctrl_reset;
            transfer_count_reg <= result_transfer_pkg::count_reset;
            block_start_addr   <= result_transfer_pkg::start_reset;
        end else begin
            if (wr_ctrl) begin
                ctrl <= pwdata[7:0]; // see R3
            end
            if (wr_count) begin
                transfer_count_reg <= pwdata[7:0];
            end
            if (wr_start) begin
                block_start_addr <= {pwdata[15:1], 1'b0}; // see R24
            end
        end
    end

    // trigger capture; a load during a running transfer is dropped since
    // the converter cannot finish a conversion within four cycles
    always_ff @(posedge mclk) begin
        if (rst) begin
            start_q     <= 1'b0;
            result_word <= 16'h0000;
        end else begin
            start_q <= result_load & unit_active & ~xif.busy & ~start_q; // see R1
            if (result_load & unit_active & ~xif.busy & ~start_q) begin
                result_word <= {6'h00, conversion_result};
            end
        end
    end

    // hidden pointer, counter and block walk
    always_ff @(posedge mclk) begin
        if (rst) begin
            pointer      <= result_transfer_pkg::start_reset;
            counter      <= result_transfer_pkg::count_reset;
            in_block_two <= 1'b0;
            halted       <= 1'b0;
        end else if (wr_start || wr_count) begin
            // rewriting the start address or count rearms the walk at block one
            pointer      <= wr_start ? {pwdata[15:1], 1'b0} : block_start_addr; // see R6
            counter      <= wr_count ? pwdata[7:0] : transfer_count_reg; // see R5
            in_block_two <= 1'b0;
            halted       <= 1'b0;
        end else if (xif.done) begin
            pointer <= pointer + result_transfer_pkg::word_step; // see R4 see R5
            counter <= counter - 8'h01;
            if (last_word) begin
                if (two_block_select && !in_block_two) begin
                    // pointer runs on into block two right after block one
                    counter      <= transfer_count_reg; // see R10
                    in_block_two <= 1'b1; // see R8
                end else if (continuous_transfer) begin
                    pointer      <= block_start_addr; // see R12
                    counter      <= transfer_count_reg;
                    in_block_two <= 1'b0;
                end else begin
                    halted       <= 1'b1; // see R13
                    in_block_two <= 1'b0;
                end
            end
        end
    end

    // block-one-full marks which half software may read
    always_ff @(posedge mclk) begin
        if (rst) begin
            block_one_full <= 1'b0;
        end else if (block_done_set && two_block_select) begin
            block_one_full <= ~in_block_two; // see R9
        end else if (block_done_set) begin
            block_one_full <= 1'b0; // see R11
        end
    end

    // flag, request and reference
    always_ff @(posedge mclk) begin
        if (rst) begin
            conv_irq_flag <= 1'b0;
            irq           <= 1'b0;
            ref_gen_on    <= 1'b0;
        end else begin
            conv_irq_flag <= next_flag; // see R9
            irq           <= next_flag & conv_irq_enable & global_irq_enable; // see R22
            ref_gen_on    <= is_temp_channel(input_channel_select); // see R19
        end
    end
endmodule

// >>> mem_bus_model.sv
// memory bus partner: word store that keeps the last transfer write to each address
`timescale 1ns/1ps
module mem_bus_model (
    input wire logic        mclk,
    input wire logic        mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata
);
    logic [15:0] mem [logic [15:0]];
    int          n_writes = 0;

    // raw address is kept, so an odd pointer lands apart from its word
    always @(posedge mclk) begin
        if (mem_we === 1'b1) begin
            mem[mem_addr] = mem_wdata;
            n_writes++;
        end
    end

    // an untouched word reads unknown, so a missed write never matches
    function automatic logic [15:0] peek(input logic [15:0] a);
        return mem.exists(a) ? mem[a] : 16'hxxxx;
    endfunction
endmodule

// >>> rtc_assertions.sv
// port checker for the result transfer controller
`timescale 1ns/1ps
module rtc_assertions (
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        result_load,
    input wire logic        global_irq_enable,
    input wire logic        cpu_off,
    input wire logic        irq,
    input wire logic        cpu_stall,
    input wire logic        mclk_request,
    input wire logic        mem_we,
    input wire logic [15:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic        ref_gen_on,
    input wire logic        block_one_full
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    // decode helpers: five mapped words, sensor code on the written channel field
    logic mapped;
    logic temp_sel;
    assign mapped = paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    assign temp_sel = pwdata[7:4] == 4'ha;

    sequence s_setup; psel && !penable; endsequence
    sequence s_ctrl_wr; psel && penable && pready && pwrite && paddr == 8'h00; endsequence

    property p_ready; s_setup |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_err; s_setup ##0 !mapped |=> pslverr && pready; endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_we_pulse; mem_we |=> !mem_we; endproperty
    a_we_pulse: assert property (p_we_pulse) else $error("write longer than a cycle");
    property p_stall; cpu_stall |-> mem_we; endproperty
    a_stall: assert property (p_stall) else $error("stall outside transfer cycle");
    property p_word; mem_we |-> !mem_addr[0] && mem_wdata[15:10] == 6'h00; endproperty
    a_word: assert property (p_word) else $error("write not an aligned result word");
    property p_active; mem_we && cpu_stall |-> $past(result_load, 3); endproperty
    a_active: assert property (p_active) else $error("active transfer off time");
    property p_light; mem_we && cpu_off && !mclk_request |-> !cpu_stall && $past(result_load, 4); endproperty
    a_light: assert property (p_light) else $error("low power transfer wrong");
    property p_irq; irq |-> $past(global_irq_enable); endproperty
    a_irq: assert property (p_irq) else $error("irq without global enable");
    property p_ref; s_ctrl_wr |-> ##2 ref_gen_on == $past(temp_sel, 2); endproperty
    a_ref: assert property (p_ref) else $error("reference generator wrong");
    property p_b1; $rose(block_one_full) |-> $past(mem_we, 2) || $past(mem_we, 3) || $past(mem_we, 4); endproperty
    a_b1: assert property (p_b1) else $error("block one full without transfer");
endmodule

bind adc_result_transfer_ctrl rtc_assertions u_chk (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .result_load(result_load),
    .global_irq_enable(global_irq_enable), .cpu_off(cpu_off), .irq(irq), .cpu_stall(cpu_stall),
    .mclk_request(mclk_request), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .ref_gen_on(ref_gen_on), .block_one_full(block_one_full)
);

// >>> test_adc_result_transfer_ctrl.sv
// self-checking bench for the result transfer controller
`timescale 1ns/1ps
module test_adc_result_transfer_ctrl;
    logic        mclk, rst, psel, penable, pwrite, result_load, global_irq_enable, irq_serviced;
    logic        cpu_off, main_clock_off, deep_low_power_level, pready, pslverr, irq, cpu_stall;
    logic        mclk_request, internal_osc_clock_sel, mem_we, ref_gen_on, block_one_full;
    logic        saw_stall, saw_req, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [9:0]  conversion_result, cur;
    logic [15:0] mem_addr, mem_wdata, sa;
    logic [15:0] exp_mem [logic [15:0]];
    int          n_mismatch = 0, checks = 0, gap = 12, m;

    adc_result_transfer_ctrl dut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conversion_result(conversion_result), .result_load(result_load),
        .global_irq_enable(global_irq_enable), .irq_serviced(irq_serviced), .cpu_off(cpu_off),
        .main_clock_off(main_clock_off), .deep_low_power_level(deep_low_power_level), .irq(irq),
        .cpu_stall(cpu_stall), .mclk_request(mclk_request), .internal_osc_clock_sel(internal_osc_clock_sel),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .ref_gen_on(ref_gen_on),
        .block_one_full(block_one_full)
    );
    mem_bus_model mdl (.mclk(mclk), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

    initial begin
        mclk = 0;
        forever #5 mclk = ~mclk;
    end

    // stall and oscillator clock request seen since the last load
    always @(posedge mclk) begin
        if (cpu_stall === 1'b1) saw_stall = 1;
        if (mclk_request === 1'b1 && internal_osc_clock_sel === 1'b1) saw_req = 1;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; the wait ends only on pready or the watchdog
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask

    task automatic load();
        @(posedge mclk);
        cur = 10'($urandom);
        saw_stall = 0;
        saw_req = 0;
        result_load <= 1;
        conversion_result <= cur;
        @(posedge mclk);
        result_load <= 0;
        repeat (gap) @(posedge mclk);
    endtask

    // arm one mode, run its loads through a reference of pointer, counter and flags
    task automatic blk(input logic [7:0] ctrl, input logic [7:0] n);
        int          cnt, k, w0, nw = 0;
        logic        b2 = 0, halt = 0, fl = 0, b1 = 0;
        logic [15:0] ptr;
        k = ctrl[1] ? 2 * (1 + ctrl[0]) * n : (1 + ctrl[0]) * n + 1;
        sa = 16'($urandom) & 16'hfff0;
        apb(1, 8'h00, {24'h0, ctrl});
        apb(1, 8'h08, {16'h0, sa});
        apb(1, 8'h04, {24'h0, n});
        apb(1, 8'h0c, 32'h1);
        exp_mem.delete();
        ptr = sa;
        cnt = n;
        w0 = mdl.n_writes;
        for (int i = 0; i <= k; i++) begin
            if (i == k) begin
                if (ctrl != 8'h00) break;
                apb(1, 8'h08, {16'h0, sa});
                halt = 0;
                ptr = sa;
                cnt = n;
            end
            load();
            if (!halt) begin
                exp_mem[ptr] = {6'h0, cur};
                ptr += 16'h2;
                cnt--;
                nw++;
                check("cpu stall", saw_stall, !cpu_off);
                check("clock request", saw_req, main_clock_off);
                check("clock off again", mclk_request, 0);
                if (cnt == 0) begin
                    fl = 1;
                    cnt = n;
                    b1 = ctrl[0] && !b2;
                    b2 = b1;
                    halt = !b1 && !ctrl[1];
                    if (!b1) ptr = sa;
                end
            end
            apb(0, 8'h0c, 0);
            check("status", rd & 32'h7, {29'h0, !halt, b1, fl});
            check("block one pin", block_one_full, b1);
            apb(1, 8'h0c, 32'h1);
            fl = 0;
        end
        check("write count", mdl.n_writes - w0, nw);
        foreach (exp_mem[a]) check("memory word", mdl.peek(a), exp_mem[a]);
    endtask

    task automatic final_report();
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard: the whole run needs well under a quarter of this
    initial begin
        #200000;
        n_mismatch++;
        final_report();
    end

    initial begin
        {rst, psel, penable, pwrite, result_load, global_irq_enable, irq_serviced} = 7'h01 << 6;
        {cpu_off, main_clock_off, deep_low_power_level} = 3'h0;
        {paddr, pwdata, conversion_result} = 0;
        void'($urandom(32'h99bd2352));
        repeat (6) @(posedge mclk);
        rst <= 0;
        apb(0, 8'h08, 0);
        check("start reset", rd, 32'h200);
        apb(0, 8'h14, 0);
        check("unmapped", {31'h0, err}, 1);
        check("unmapped data", rd, 0);
        // count zero: every load raises the flag, irq follows the enables
        apb(1, 8'h00, 32'h4);
        m = mdl.n_writes;
        global_irq_enable <= 1;
        load();
        check("irq", irq, 1);
        check("no transfer", mdl.n_writes, m);
        irq_serviced <= 1;
        @(posedge mclk);
        irq_serviced <= 0;
        repeat (3) @(posedge mclk);
        check("serviced", irq, 0);
        global_irq_enable <= 0;
        load();
        apb(0, 8'h0c, 0);
        check("flag", rd[0], 1);
        check("irq masked", irq, 0);
        apb(1, 8'h0c, 32'h1);
        apb(0, 8'h0c, 0);
        check("flag cleared", rd[0], 0);
        // all four block and continuous modes, then the low power cases
        for (m = 0; m < 4; m++) blk(8'(m), 8'(1 + $urandom_range(2)));
        cpu_off <= 1;
        blk(8'h01, 8'h1);
        main_clock_off <= 1;
        blk(8'h00, 8'h2);
        deep_low_power_level <= 1;
        gap = 700;
        blk(8'h00, 8'h1);
        // channel codes around the sensor code
        for (m = 9; m < 12; m++) begin
            // no load is made while the sensor is selected, so no short sample period arises
            apb(1, 8'h00, 32'(m << 4));
            repeat (2) @(posedge mclk);
            check("ref gen", ref_gen_on, m == 10);
        end
        final_report();
    end
endmodule
